// *** eiem_pkg.sv ***
package eiem_pkg;
  // Summary of operation
  // - write-data no-ack status set raises interrupt when its enable bit 20 is set.
  // - corrected read data status set raises interrupt when enable bit 19 set.
  // - no read response status set raises interrupt when enable bit 18 set.
  // - read sequence error status set raises interrupt when enable bit 17 set.
  // - read error response status set raises interrupt when enable bit 16 set.
  // - command no-ack status set raises interrupt when enable bit 15 set.
  // - transaction timeout status set raises interrupt when enable bit 13 set.
  // - invalid page frame status set raises interrupt when enable bit 11 set.
  // - either correctable ECC status (map or DMA) raises interrupt when bit 10 set.
  // - either uncorrectable ECC status (map or DMA) raises interrupt when bit 9 set.

  // enable register at 12'h000; pending register (write-one-to-clear) at 12'h004
  localparam logic [11:0] EIEM_ENABLE_ADDR  = 12'h000;
  localparam logic [11:0] EIEM_PENDING_ADDR = 12'h004;
  localparam logic [31:0] EIEM_ENABLE_RESET = 32'h0000_0000;
  // writable enable bits 20:15, 13, 11:9
  localparam logic [31:0] EIEM_ENABLE_MASK  = 32'h001F_AE00;

  localparam int EIEM_BIT_WDATA_NOACK = 20;
  localparam int EIEM_BIT_CORR_READ   = 19;
  localparam int EIEM_BIT_NO_RSP      = 18;
  localparam int EIEM_BIT_READ_SEQ    = 17;
  localparam int EIEM_BIT_READ_ERR    = 16;
  localparam int EIEM_BIT_CMD_NOACK   = 15;
  localparam int EIEM_BIT_TIMEOUT     = 13;
  localparam int EIEM_BIT_BAD_PAGE    = 11;
  localparam int EIEM_BIT_CECC        = 10;
  localparam int EIEM_BIT_UECC        = 9;

  // status inputs, positions in their own registers
  localparam int EIEM_SUM_MAP_CECC = 13;
  localparam int EIEM_SUM_MAP_UECC = 12;
  localparam int EIEM_SUM_BAD_PAGE = 11;
  localparam int EIEM_SUM_DMA_CECC = 10;
  localparam int EIEM_SUM_DMA_UECC = 9;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } eiem_req_t;
endpackage

// *** eiem_edge.sv ***
`timescale 1ns/1ps
module eiem_edge
  import eiem_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] prev_r;

  // status bits are on pclk already; only a rising edge means "sets"
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
endmodule

// *** eiem_top.sv ***
`timescale 1ns/1ps
module eiem_top
  import eiem_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] system_bus_error_status,
  input  wire logic [31:0] adapter_error_summary,
  output logic             irq_req
);

  ////////////////////////////////////////////////////////////////
  eiem_req_t   req;
  logic [31:0] enable_r;
  logic [31:0] pending_r;
  logic [31:0] xrise;
  logic [31:0] arise;
  logic [31:0] evt;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        clr_en;

  assign req     = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign pready  = 1'b1;
  assign addr_ok = (req.addr == EIEM_ENABLE_ADDR) || (req.addr == EIEM_PENDING_ADDR);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && req.write && (req.addr == EIEM_ENABLE_ADDR);
  assign clr_en  = psel && penable && req.write && (req.addr == EIEM_PENDING_ADDR);
  assign rd_en   = psel && !penable && !req.write;

  ////////////////////////////////////////////////////////////////
  // enable register; reserved positions masked off on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= EIEM_ENABLE_RESET;
    end else if (wr_en) begin
      enable_r <= req.wdata & EIEM_ENABLE_MASK;
    end
  end

  // read data registered in setup so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (req.addr)
        EIEM_ENABLE_ADDR:  prdata <= enable_r & EIEM_ENABLE_MASK;
        EIEM_PENDING_ADDR: prdata <= pending_r;
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  eiem_edge #(.W(32)) u_xedge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (system_bus_error_status),
    .rise    (xrise)
  );

  eiem_edge #(.W(32)) u_aedge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (adapter_error_summary),
    .rise    (arise)
  );

  // map each setting status bit onto its enable position
  always_comb begin
    evt = 32'h0000_0000;
    evt[EIEM_BIT_WDATA_NOACK] = xrise[EIEM_BIT_WDATA_NOACK];
    evt[EIEM_BIT_CORR_READ]   = xrise[EIEM_BIT_CORR_READ];
    evt[EIEM_BIT_NO_RSP]      = xrise[EIEM_BIT_NO_RSP];
    evt[EIEM_BIT_READ_SEQ]    = xrise[EIEM_BIT_READ_SEQ];
    evt[EIEM_BIT_READ_ERR]    = xrise[EIEM_BIT_READ_ERR];
    evt[EIEM_BIT_CMD_NOACK]   = xrise[EIEM_BIT_CMD_NOACK];
    evt[EIEM_BIT_TIMEOUT]     = xrise[EIEM_BIT_TIMEOUT];
    evt[EIEM_BIT_BAD_PAGE]    = arise[EIEM_SUM_BAD_PAGE];
    evt[EIEM_BIT_CECC]        = arise[EIEM_SUM_MAP_CECC] | arise[EIEM_SUM_DMA_CECC];
    evt[EIEM_BIT_UECC]        = arise[EIEM_SUM_MAP_UECC] | arise[EIEM_SUM_DMA_UECC];
  end

  // pending interrupt causes; write-one-to-clear, a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_r <= 32'h0000_0000;
    end else begin
      pending_r <= (pending_r & ~(clr_en ? req.wdata : 32'h0000_0000)) | (evt & enable_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= |(evt & enable_r);
    end
  end

  ////////////////////////////////////////////////////////////////
  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      (enable_r[14] == 1'b0) && (enable_r[12] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bit set");

  property p_wdata_noack;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_WDATA_NOACK] && enable_r[EIEM_BIT_WDATA_NOACK]) |=> irq_req;
  endproperty
  a_wdata_noack: assert property (p_wdata_noack) else $error("write-data noack irq missing");

  property p_wdata_noack_pend;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_WDATA_NOACK] && enable_r[EIEM_BIT_WDATA_NOACK]) |=> pending_r[EIEM_BIT_WDATA_NOACK];
  endproperty
  a_wdata_noack_pend: assert property (p_wdata_noack_pend) else $error("write-data noack not pending");

  property p_corr_read;
    @(posedge pclk) disable iff (!presetn)
      $rose(system_bus_error_status[EIEM_BIT_CORR_READ]) && enable_r[EIEM_BIT_CORR_READ] |=> irq_req;
  endproperty
  a_corr_read: assert property (p_corr_read) else $error("corrected read irq missing");

  property p_corr_read_pend;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_CORR_READ] && enable_r[EIEM_BIT_CORR_READ]) |=> pending_r[EIEM_BIT_CORR_READ];
  endproperty
  a_corr_read_pend: assert property (p_corr_read_pend) else $error("corrected read not pending");

  property p_no_rsp;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_NO_RSP] && enable_r[EIEM_BIT_NO_RSP]) |=> pending_r[EIEM_BIT_NO_RSP];
  endproperty
  a_no_rsp: assert property (p_no_rsp) else $error("no read response not pending");

  property p_no_rsp_irq;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_NO_RSP] && enable_r[EIEM_BIT_NO_RSP]) |=> irq_req;
  endproperty
  a_no_rsp_irq: assert property (p_no_rsp_irq) else $error("no read response irq missing");

  property p_read_seq;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_READ_SEQ] && enable_r[EIEM_BIT_READ_SEQ]) |=> irq_req;
  endproperty
  a_read_seq: assert property (p_read_seq) else $error("read sequence irq missing");

  property p_read_seq_pend;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_READ_SEQ] && enable_r[EIEM_BIT_READ_SEQ]) |=> pending_r[EIEM_BIT_READ_SEQ];
  endproperty
  a_read_seq_pend: assert property (p_read_seq_pend) else $error("read sequence not pending");

  property p_read_err;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_READ_ERR] && enable_r[EIEM_BIT_READ_ERR]) |=> irq_req;
  endproperty
  a_read_err: assert property (p_read_err) else $error("read error response irq missing");

  property p_read_err_pend;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_READ_ERR] && enable_r[EIEM_BIT_READ_ERR]) |=> pending_r[EIEM_BIT_READ_ERR];
  endproperty
  a_read_err_pend: assert property (p_read_err_pend) else $error("read error response not pending");

  property p_cmd_noack;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_CMD_NOACK] && enable_r[EIEM_BIT_CMD_NOACK]) |=> pending_r[EIEM_BIT_CMD_NOACK];
  endproperty
  a_cmd_noack: assert property (p_cmd_noack) else $error("command noack not pending");

  property p_cmd_noack_irq;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_CMD_NOACK] && enable_r[EIEM_BIT_CMD_NOACK]) |=> irq_req;
  endproperty
  a_cmd_noack_irq: assert property (p_cmd_noack_irq) else $error("command noack irq missing");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_TIMEOUT] && enable_r[EIEM_BIT_TIMEOUT]) |=> irq_req;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout irq missing");

  property p_timeout_pend;
    @(posedge pclk) disable iff (!presetn)
      (xrise[EIEM_BIT_TIMEOUT] && enable_r[EIEM_BIT_TIMEOUT]) |=> pending_r[EIEM_BIT_TIMEOUT];
  endproperty
  a_timeout_pend: assert property (p_timeout_pend) else $error("timeout not pending");

  property p_bad_page;
    @(posedge pclk) disable iff (!presetn)
      (arise[EIEM_SUM_BAD_PAGE] && enable_r[EIEM_BIT_BAD_PAGE]) |=> irq_req;
  endproperty
  a_bad_page: assert property (p_bad_page) else $error("invalid page frame irq missing");

  property p_bad_page_pend;
    @(posedge pclk) disable iff (!presetn)
      (arise[EIEM_SUM_BAD_PAGE] && enable_r[EIEM_BIT_BAD_PAGE]) |=> pending_r[EIEM_BIT_BAD_PAGE];
  endproperty
  a_bad_page_pend: assert property (p_bad_page_pend) else $error("invalid page frame not pending");

  property p_cecc;
    @(posedge pclk) disable iff (!presetn)
      ($rose(adapter_error_summary[EIEM_SUM_DMA_CECC]) && enable_r[EIEM_BIT_CECC]) |=> pending_r[EIEM_BIT_CECC];
  endproperty
  a_cecc: assert property (p_cecc) else $error("correctable ecc not pending");

  property p_cecc_map;
    @(posedge pclk) disable iff (!presetn)
      ($rose(adapter_error_summary[EIEM_SUM_MAP_CECC]) && enable_r[EIEM_BIT_CECC]) |=> irq_req;
  endproperty
  a_cecc_map: assert property (p_cecc_map) else $error("correctable map ecc irq missing");

  property p_uecc;
    @(posedge pclk) disable iff (!presetn)
      ($rose(adapter_error_summary[EIEM_SUM_MAP_UECC]) && enable_r[EIEM_BIT_UECC]) |=> irq_req;
  endproperty
  a_uecc: assert property (p_uecc) else $error("uncorrectable ecc irq missing");

  property p_uecc_dma;
    @(posedge pclk) disable iff (!presetn)
      ($rose(adapter_error_summary[EIEM_SUM_DMA_UECC]) && enable_r[EIEM_BIT_UECC]) |=> pending_r[EIEM_BIT_UECC];
  endproperty
  a_uecc_dma: assert property (p_uecc_dma) else $error("uncorrectable dma ecc not pending");

  // a masked cause must never leave a trace in the pending word
  property p_masked_no_pend;
    @(posedge pclk) disable iff (!presetn)
      (!clr_en && ((pending_r & ~enable_r) == 32'h0000_0000)) |=> ((pending_r & ~$past(enable_r)) == 32'h0000_0000);
  endproperty
  a_masked_no_pend: assert property (p_masked_no_pend) else $error("masked cause became pending");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (clr_en && (req.wdata == 32'hFFFF_FFFF) && ((evt & enable_r) == 32'h0000_0000)) |=> (pending_r == 32'h0000_0000);
  endproperty
  a_clear: assert property (p_clear) else $error("pending not cleared");

  property p_masked_quiet;
    @(posedge pclk) disable iff (!presetn)
      (evt & enable_r) == 32'h0000_0000 |=> !irq_req;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("irq without enabled cause");

  c_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en);
  c_irq:   cover property (@(posedge pclk) disable iff (!presetn) irq_req);
  c_clr:   cover property (@(posedge pclk) disable iff (!presetn) clr_en && |evt);
  c_err:   cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_ecc:   cover property (@(posedge pclk) disable iff (!presetn) evt[EIEM_BIT_CECC] && enable_r[EIEM_BIT_CECC]);
endmodule

// *** test_error_interrupt_enable_mask.sv ***
`timescale 1ns/1ps
module test_error_interrupt_enable_mask
  import eiem_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] sbus_st;
  logic [31:0] sum_st;
  logic        irq_req;
  logic [32:0] rd_q[$];
  logic        irq_q[$];
  logic        mon_exp;
  logic [31:0] en;
  int          error_cnt;
  int          compares;
  int          seed;
  // event table: first seven sources sit in the system bus status word
  int          st_bit[12] = '{20, 19, 18, 17, 16, 15, 13, 11, 13, 10, 12, 9};
  int          en_bit[12] = '{20, 19, 18, 17, 16, 15, 13, 11, 10, 10, 9, 9};

  eiem_top uut (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .system_bus_error_status (sbus_st),
    .adapter_error_summary   (sum_st),
    .irq_req                 (irq_req)
  );

  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wrap_up;
    // notes still queued mean a read or an interrupt never showed up
    error_cnt += rd_q.size() + irq_q.size();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // entered right after a rising edge; one idle edge at the end drops psel low for a cycle between transfers
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task rd(input logic [11:0] a, input logic [32:0] exp);
    rd_q.push_back(exp);
    apb(1'h0, a, 32'h0);
  endtask

  task ev(input int i, input logic [31:0] e);
    if (e[en_bit[i]] === 1'h1)
      irq_q.push_back(1'h1);
    if (i < 7)
      sbus_st[st_bit[i]] <= 1'h1;
    else
      sum_st[st_bit[i]] <= 1'h1;
    repeat (2) @(posedge pclk);
    sbus_st <= 32'h0;
    sum_st <= 32'h0;
    repeat (3) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'h1)
      check("read", {pslverr, prdata}, rd_q.pop_front());
    if (irq_req !== 1'h0) begin
      mon_exp = (irq_q.size() > 0) ? irq_q.pop_front() : 1'h0;
      check("irq", {32'h0, irq_req}, {32'h0, mon_exp});
    end
  end

  initial begin
    #(50 * 5000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    sbus_st = 32'h0;
    sum_st = 32'h0;
    error_cnt = 0;
    compares = 0;
    seed = 32'h2D50;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h1, 12'h008, 32'hFFFF_FFFF);
    rd(12'h008, {1'h1, 32'h0});
    rd(EIEM_ENABLE_ADDR, {1'h0, EIEM_ENABLE_RESET});
    rd(EIEM_PENDING_ADDR, 33'h0);
    // round 0 enables all, round 3 none, the rest are random masks
    for (int r = 0; r < 4; r++) begin
      en = (r == 0) ? 32'hFFFF_FFFF : (r == 3) ? 32'h0 : $random(seed);
      apb(1'h1, EIEM_ENABLE_ADDR, en);
      rd(EIEM_ENABLE_ADDR, {1'h0, en & EIEM_ENABLE_MASK});
      for (int i = 0; i < 12; i++)
        ev(i, en & EIEM_ENABLE_MASK);
      // every enabled cause fired this round (bits 10 and 9 twice each), so all of them are pending
      rd(EIEM_PENDING_ADDR, {1'h0, en & EIEM_ENABLE_MASK});
      apb(1'h1, EIEM_PENDING_ADDR, 32'hFFFF_FFFF);
    end
    apb(1'h1, EIEM_PENDING_ADDR, 32'hFFFF_FFFF);
    rd(EIEM_PENDING_ADDR, 33'h0);
    repeat (4) @(posedge pclk);
    wrap_up();
  end
endmodule
